//--- rtl/rmb_pkg.sv
// package: register map, field layout and carrier types of the regulator mode register bank
package rmb_pkg;
  // register addresses on the management bus
  localparam logic [7:0] ADDR_BUCK4_CFG = 8'h45;
  localparam logic [7:0] ADDR_AUX1_ACT = 8'h50;
  localparam logic [7:0] ADDR_AUX1_LPM = 8'h51;
  localparam logic [7:0] ADDR_AUX1_HIB = 8'h52;
  // buck configuration field positions
  localparam int CFG_PHASE_BIT = 4;
  localparam int CFG_RATE_LSB = 2;
  localparam int CFG_REN_BIT = 1;
  localparam int CFG_SOFT_CONTROL_SELECT_BIT = 0;
  // buck configuration value after reset
  localparam logic [7:0] CFG_RESET = 8'h00;
  // per-mode register field positions
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_RSVD_BIT = 6;
  localparam int CODE_W = 6;
  // per-mode enable values after reset
  localparam logic ACT_EN_RESET = 1'h1;
  localparam logic LPM_EN_RESET = 1'h1;
  localparam logic HIB_EN_RESET = 1'h0;
  // cycles after reset release before straps are caught (three-stage sync settles)
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // processor power mode
  typedef enum logic [1:0] {
    RMB_MODE_ACTIVE = 2'b00,
    RMB_MODE_LOW = 2'b01,
    RMB_MODE_HIB = 2'b11
  } rmb_pmode_t;

  // one per-mode setting: enable plus output level code
  typedef struct packed {
    logic enable;
    logic [CODE_W-1:0] output_level_code;
  } rmb_setting_t;

  // register write/read request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rmb_req_t;
endpackage

//--- rtl/rmb_regulator_mode_register_bank.sv
// module: buck4 configuration tail and aux regulator 1 per-mode registers
//
// Contract
// - phase bit one selects 180 degree switching
// - bits three-two set voltage scaling rate
// - soft control clear makes enable bit inert
// - soft control set: enable bit drives channel
// - active register 0x50 enable, resets one
// - low-power register 0x51 enable, resets one
// - hibernate register 0x52 enable, resets zero
// - six-bit level code defaults from pins
`timescale 1ns/100ps
module rmb_regulator_mode_register_bank (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire rmb_pkg::rmb_req_t req_in,
  input wire logic [rmb_pkg::CODE_W-1:0] strap_code_in,
  input wire logic [1:0] power_mode_in,
  input wire logic channel_on_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic phase_inverted_out,
  output logic [1:0] voltage_scaling_rate_out,
  output logic buck4_enable_out,
  output logic buck4_override_out,
  output rmb_pkg::rmb_setting_t aux1_applied_out
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] cfg_ff; // buck4 configuration image
  rmb_pkg::rmb_setting_t act_ff; // active-mode setting
  rmb_pkg::rmb_setting_t lpm_ff; // low-power-mode setting
  rmb_pkg::rmb_setting_t hib_ff; // hibernate-mode setting
  logic [rmb_pkg::CODE_W-1:0] strap_s1_ff; // first stage, read only by stage two
  logic [rmb_pkg::CODE_W-1:0] strap_s2_ff;
  logic [rmb_pkg::CODE_W-1:0] strap_s3_ff;
  logic [1:0] mode_s1_ff; // first stage, read only by stage two
  logic [1:0] mode_s2_ff;
  logic [1:0] mode_s3_ff;
  logic [1:0] mode_ff; // accepted power mode
  logic [1:0] strap_wait_ff; // settle count after reset release
  logic strap_done_ff; // level codes caught from pins
  logic wr_cfg, wr_act, wr_lpm, wr_hib;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  always_comb
  begin
    wr_cfg = 1'b0;
    wr_act = 1'b0;
    wr_lpm = 1'b0;
    wr_hib = 1'b0;
    if (!req_in.wr)
      wr_cfg = 1'b0; // no write this cycle
    else if (req_in.addr == rmb_pkg::ADDR_BUCK4_CFG)
      wr_cfg = 1'b1;
    else if (req_in.addr == rmb_pkg::ADDR_AUX1_ACT)
      wr_act = 1'b1;
    else if (req_in.addr == rmb_pkg::ADDR_AUX1_LPM)
      wr_lpm = 1'b1;
    else if (req_in.addr == rmb_pkg::ADDR_AUX1_HIB)
      wr_hib = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; straps and mode come from outside this clock
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      strap_s1_ff <= '0;
      strap_s2_ff <= '0;
      strap_s3_ff <= '0;
      mode_s1_ff <= 2'h0;
      mode_s2_ff <= 2'h0;
      mode_s3_ff <= 2'h0;
    end
    else
    begin
      strap_s1_ff <= strap_code_in;
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
      mode_s1_ff <= power_mode_in;
      mode_s2_ff <= mode_s1_ff;
      mode_s3_ff <= mode_s2_ff;
    end
  end

  // mode change counts only once stages two and three agree
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      mode_ff <= rmb_pkg::RMB_MODE_ACTIVE;
    else if (mode_s2_ff == mode_s3_ff)
      mode_ff <= mode_s3_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap catch: codes cannot be loaded in async reset, so take them after release
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      strap_wait_ff <= 2'h0;
      strap_done_ff <= 1'b0;
    end
    else if (strap_wait_ff != rmb_pkg::STRAP_WAIT)
      strap_wait_ff <= strap_wait_ff + 2'h1;
    else
      strap_done_ff <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // buck4 configuration register
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      cfg_ff <= rmb_pkg::CFG_RESET;
    else if (wr_cfg)
      cfg_ff <= req_in.wdata;
  end

  // channel on/off: register bit only counts under soft control
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      buck4_enable_out <= 1'b0;
      buck4_override_out <= 1'b0;
      phase_inverted_out <= 1'b0;
      voltage_scaling_rate_out <= 2'h0;
    end
    else
    begin
      phase_inverted_out <= cfg_ff[rmb_pkg::CFG_PHASE_BIT];
      voltage_scaling_rate_out <= cfg_ff[rmb_pkg::CFG_RATE_LSB +: 2];
      buck4_override_out <= cfg_ff[rmb_pkg::CFG_SOFT_CONTROL_SELECT_BIT];
      if (cfg_ff[rmb_pkg::CFG_SOFT_CONTROL_SELECT_BIT])
        buck4_enable_out <= cfg_ff[rmb_pkg::CFG_REN_BIT];
      else
        buck4_enable_out <= channel_on_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-mode settings; the reserved bit is not stored and reads zero
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      act_ff <= '{enable: rmb_pkg::ACT_EN_RESET, output_level_code: '0};
      lpm_ff <= '{enable: rmb_pkg::LPM_EN_RESET, output_level_code: '0};
      hib_ff <= '{enable: rmb_pkg::HIB_EN_RESET, output_level_code: '0};
    end
    else if (!strap_done_ff && strap_wait_ff == rmb_pkg::STRAP_WAIT)
    begin
      // one-shot load of pin default; level codes written before it are overruled
      act_ff.output_level_code <= strap_s3_ff;
      lpm_ff.output_level_code <= strap_s3_ff;
      hib_ff.output_level_code <= strap_s3_ff;
    end
    else
    begin
      if (wr_act)
        act_ff <= {req_in.wdata[rmb_pkg::MODE_EN_BIT], req_in.wdata[rmb_pkg::CODE_W-1:0]};
      if (wr_lpm)
        lpm_ff <= {req_in.wdata[rmb_pkg::MODE_EN_BIT], req_in.wdata[rmb_pkg::CODE_W-1:0]};
      if (wr_hib)
        hib_ff <= {req_in.wdata[rmb_pkg::MODE_EN_BIT], req_in.wdata[rmb_pkg::CODE_W-1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apply setting for the present mode
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      aux1_applied_out <= '0;
    else
      case (mode_ff)
        rmb_pkg::RMB_MODE_ACTIVE: aux1_applied_out <= act_ff;
        rmb_pkg::RMB_MODE_LOW: aux1_applied_out <= lpm_ff;
        rmb_pkg::RMB_MODE_HIB: aux1_applied_out <= hib_ff;
        default: aux1_applied_out <= lpm_ff; // code 10 treated as low power
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: one cycle after request, unmapped reads zero
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_out <= 8'h00;
      rvalid_out <= 1'b0;
    end
    else
    begin
      rvalid_out <= req_in.rd;
      if (!req_in.rd)
        rdata_out <= 8'h00;
      else if (req_in.addr == rmb_pkg::ADDR_BUCK4_CFG)
        rdata_out <= cfg_ff;
      else if (req_in.addr == rmb_pkg::ADDR_AUX1_ACT)
        rdata_out <= {act_ff.enable, 1'b0, act_ff.output_level_code};
      else if (req_in.addr == rmb_pkg::ADDR_AUX1_LPM)
        rdata_out <= {lpm_ff.enable, 1'b0, lpm_ff.output_level_code};
      else if (req_in.addr == rmb_pkg::ADDR_AUX1_HIB)
        rdata_out <= {hib_ff.enable, 1'b0, hib_ff.output_level_code};
      else
        rdata_out <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_phase;
    @(posedge clock_in) disable iff (rst_in)
    wr_cfg ##2 1'b1 |-> phase_inverted_out == $past(req_in.wdata[4], 2);
  endproperty
  a_phase: assert property (p_phase) else $error("phase output wrong");

  property p_rate;
    @(posedge clock_in) disable iff (rst_in)
    wr_cfg ##2 1'b1 |-> voltage_scaling_rate_out == $past(req_in.wdata[3:2], 2);
  endproperty
  a_rate: assert property (p_rate) else $error("rate output wrong");

  property p_inert;
    @(posedge clock_in) disable iff (rst_in)
    !cfg_ff[0] |=> buck4_enable_out == $past(channel_on_in);
  endproperty
  a_inert: assert property (p_inert) else $error("enable bit not inert");

  property p_soft;
    @(posedge clock_in) disable iff (rst_in)
    wr_cfg && req_in.wdata[0] ##2 1'b1 |-> buck4_enable_out == $past(req_in.wdata[1], 2);
  endproperty
  a_soft: assert property (p_soft) else $error("soft enable ignored");

  // keyed on the address of the read, not on data, so a same-cycle write cannot mislead it
  property p_rsvd;
    @(posedge clock_in) disable iff (rst_in)
    rvalid_out && $past(req_in.addr) != rmb_pkg::ADDR_BUCK4_CFG |-> !rdata_out[6];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read nonzero");

  property p_strap;
    @(posedge clock_in) disable iff (rst_in)
    $rose(strap_done_ff) |-> hib_ff.output_level_code == $past(strap_s3_ff);
  endproperty
  a_strap: assert property (p_strap) else $error("pin default not loaded");

  property p_hib;
    @(posedge clock_in) disable iff (rst_in)
    mode_ff == rmb_pkg::RMB_MODE_HIB |=> aux1_applied_out == $past(hib_ff);
  endproperty
  a_hib: assert property (p_hib) else $error("hibernate setting not applied");

  property p_act;
    @(posedge clock_in) disable iff (rst_in)
    mode_ff == rmb_pkg::RMB_MODE_ACTIVE |=> aux1_applied_out == $past(act_ff);
  endproperty
  a_act: assert property (p_act) else $error("active setting not applied");

endmodule

//--- test/rmb_host_model.sv
// host software model issuing register requests to the mode register bank
`timescale 1ns/100ps
module rmb_host_model (
  input wire logic clock_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output rmb_pkg::rmb_req_t req_out
);
  // idle request at time zero
  initial req_out = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // one write cycle, raised at a falling edge and held over the taking edge
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    // per-mode registers: reserved bit always written as zero
    if (addr inside {rmb_pkg::ADDR_AUX1_ACT, rmb_pkg::ADDR_AUX1_LPM, rmb_pkg::ADDR_AUX1_HIB})
    begin
      d[rmb_pkg::MODE_RSVD_BIT] = 1'b0;
    end
    @(negedge clock_in);
    req_out = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: d};
    @(negedge clock_in);
    // released: leftovers inverted so stale address or data is never trusted
    req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~d};
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one read cycle; the answer stands right after the taking edge and is read at the next falling edge
  task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic valid);
    @(negedge clock_in);
    req_out = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge clock_in);
    data = rdata_in;
    valid = rvalid_in;
    req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hff};
  endtask
endmodule

//--- test/tb_top.sv
// self-checking bench for the regulator mode register bank
`timescale 1ns/100ps
module tb_top;
  localparam logic [5:0] STRAP = 6'h2a; // pin-selected default level code
  logic clock_in;
  logic rst_in;
  logic [5:0] strap_code_in;
  logic [1:0] power_mode_in;
  logic channel_on_in;
  rmb_pkg::rmb_req_t req;
  logic [7:0] rdata_out;
  logic rvalid_out;
  logic phase_inverted_out;
  logic [1:0] voltage_scaling_rate_out;
  logic buck4_enable_out;
  logic buck4_override_out;
  rmb_pkg::rmb_setting_t aux1_applied_out;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  rmb_regulator_mode_register_bank uut (.clock_in(clock_in), .rst_in(rst_in), .req_in(req),
    .strap_code_in(strap_code_in), .power_mode_in(power_mode_in),
    .channel_on_in(channel_on_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .phase_inverted_out(phase_inverted_out),
    .voltage_scaling_rate_out(voltage_scaling_rate_out),
    .buck4_enable_out(buck4_enable_out), .buck4_override_out(buck4_override_out),
    .aux1_applied_out(aux1_applied_out));
  rmb_host_model host (.clock_in(clock_in), .rdata_in(rdata_out), .rvalid_in(rvalid_out),
    .req_out(req));

  ////////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // hang guard: the run needs only about 110 cycles
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host.read(addr, d, v);
    check({7'h00, v}, 8'h01);
    check(d, exp);
  endtask

  // outputs are registered behind the stored value: two edges to settle
  task automatic cfg_write(input logic [7:0] v);
    host.write(rmb_pkg::ADDR_BUCK4_CFG, v);
    repeat (2) @(negedge clock_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_defaults();
    read_check(rmb_pkg::ADDR_BUCK4_CFG, rmb_pkg::CFG_RESET);
    read_check(rmb_pkg::ADDR_AUX1_ACT, {rmb_pkg::ACT_EN_RESET, 1'b0, STRAP});
    read_check(rmb_pkg::ADDR_AUX1_LPM, {rmb_pkg::LPM_EN_RESET, 1'b0, STRAP});
    read_check(rmb_pkg::ADDR_AUX1_HIB, {rmb_pkg::HIB_EN_RESET, 1'b0, STRAP});
    read_check(8'h46, 8'h00);
    check({1'b0, aux1_applied_out}, {1'b0, rmb_pkg::ACT_EN_RESET, STRAP});
  endtask

  task automatic t_buck_cfg();
    cfg_write(8'h13);
    check({7'h00, phase_inverted_out}, 8'h01);
    check({6'h00, buck4_override_out, buck4_enable_out}, 8'h03);
    cfg_write(8'h11);
    check({7'h00, buck4_enable_out}, 8'h00);
    for (int r = 0; r < 4; r++)
    begin
      cfg_write({4'h0, 2'(r), 2'b00});
      check({6'h00, voltage_scaling_rate_out}, 8'(r));
    end
    cfg_write(8'h02);
    check({7'h00, buck4_enable_out}, 8'h00);
    check({7'h00, phase_inverted_out}, 8'h00);
    channel_on_in = 1'b1;
    repeat (2) @(negedge clock_in);
    check({7'h00, buck4_enable_out}, 8'h01);
    read_check(rmb_pkg::ADDR_BUCK4_CFG, 8'h02);
  endtask

  // 10 is a low-power code by the designer's reading
  task automatic t_mode_select();
    logic [1:0] pm [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    logic [6:0] ex [4] = '{7'h45, 7'h0c, 7'h7f, 7'h0c};
    host.write(rmb_pkg::ADDR_AUX1_ACT, 8'h85);
    host.write(rmb_pkg::ADDR_AUX1_LPM, 8'h0c);
    host.write(rmb_pkg::ADDR_AUX1_HIB, 8'hbf);
    read_check(rmb_pkg::ADDR_AUX1_HIB, 8'hbf);
    for (int i = 0; i < 4; i++)
    begin
      power_mode_in = pm[i];
      repeat (8) @(negedge clock_in);
      check({1'b0, aux1_applied_out}, {1'b0, ex[i]});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // straps stable long before release so the pin default is caught
  initial
  begin
    rst_in = 1'b1;
    strap_code_in = STRAP;
    power_mode_in = 2'b00;
    channel_on_in = 1'b0;
    repeat (20) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (8) @(negedge clock_in);
    t_reset_defaults();
    t_buck_cfg();
    t_mode_select();
    report_and_stop();
  end
endmodule
